// *** core/fisr_pkg.sv ***
// shared constants and types of the flash interrupt and lock registers
package fisr_pkg;
    // ************************************************************
    // register indices; the byte address is four times the index
    // ************************************************************
    localparam logic [15:0] IDX_ISR = 16'hf241;
    localparam logic [15:0] IDX_LSB = 16'hf24c;
    localparam logic [15:0] IDX_LEB = 16'hf24d;
    localparam logic [15:0] IDX_WPS = 16'hf24e;
    localparam logic [15:0] IDX_CTRL = 16'hf250;
    localparam logic [15:0] IDX_FBS = 16'hf251;
    localparam logic [15:0] IDX_EVT = 16'hf252;
    localparam logic [15:0] IDX_MASK = 16'hf253;
    localparam int ADDR_W = 18;

    // ************************************************************
    // interrupt status fields and reset values
    // ************************************************************
    localparam int B_INT = 15;
    localparam int B_LOAD = 7;
    localparam int B_PROG = 6;
    localparam int B_ERASE = 5;
    localparam int B_RST = 4;
    localparam logic [15:0] ISR_COLD = 16'h8080;
    localparam logic [15:0] ISR_WARM = 16'h8010;

    // event register bits (same layout in the mask register)
    localparam int E_LOAD = 0;
    localparam int E_PROG = 1;
    localparam int E_ERASE = 2;
    localparam int E_RST = 3;
    localparam int E_CMD = 4;
    localparam int NEVT = 5;
    localparam logic [4:0] MASK_RST = 5'h00;
    localparam logic POL_RST = 1'b1;
    localparam logic [8:0] BLK_RST = 9'h000;

    // ************************************************************
    // block protection states, one-hot as read back
    // ************************************************************
    localparam int NBLK = 512;
    localparam int BLK_W = 9;
    localparam logic [2:0] LK_UNLOCKED = 3'h4;
    localparam logic [2:0] LK_LOCKED = 3'h2;
    localparam logic [2:0] LK_TIGHT = 3'h1;
    localparam logic [2:0] WP_RST = 3'h2;
    typedef enum logic [1:0] {
        LKC_LOCK = 2'b00,
        LKC_UNLOCK = 2'b01,
        LKC_TIGHT = 2'b10
    } fisr_lock_e;

    // ************************************************************
    // completion command codes
    // ************************************************************
    localparam logic [15:0] C_LD0 = 16'h0000;
    localparam logic [15:0] C_LD1 = 16'h0013;
    localparam logic [15:0] C_PG0 = 16'h0080;
    localparam logic [15:0] C_PG1 = 16'h001a;
    localparam logic [15:0] C_PG2 = 16'h001b;
    localparam logic [15:0] C_ER0 = 16'h0094;
    localparam logic [15:0] C_ER1 = 16'h0095;
    localparam logic [15:0] C_ER2 = 16'h0030;
    localparam logic [15:0] C_RS0 = 16'h00b0;
    localparam logic [15:0] C_RS1 = 16'h00f0;
    localparam logic [15:0] C_RS2 = 16'h00f3;
    localparam logic [15:0] C_MI0 = 16'h0065;
    localparam logic [15:0] C_MI1 = 16'h0023;
    localparam logic [15:0] C_MI2 = 16'h0071;
    localparam logic [15:0] C_MI3 = 16'h002a;
    localparam logic [15:0] C_MI4 = 16'h002c;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        WS_IDLE = 2'b01,
        WS_RESP = 2'b10
    } fisr_ws_e;
endpackage

// *** core/fisr_lock_if.sv ***
// link between the register block and its block protection table
`timescale 1ns/1ps
interface fisr_lock_if;
    import fisr_pkg::*;
    logic upd;
    logic [BLK_W-1:0] blk;
    fisr_lock_e kind;
    logic [BLK_W-1:0] sel;
    logic [2:0] state;
    modport tbl (input upd, input blk, input kind, input sel,
        output state);
    modport ctl (output upd, output blk, output kind, output sel,
        input state);
endinterface

// *** core/fisr_lock_table.sv ***
// per-block protection state table, one-hot state per block
`timescale 1ns/1ps
module fisr_lock_table
(
    input wire logic aclk,
    input wire logic aresetn,
    fisr_lock_if.tbl lk
);
    import fisr_pkg::*;

    typedef struct packed {
        logic [NBLK-1:0][2:0] st;
    } fisr_tbl_s;

    fisr_tbl_s cur;
    fisr_tbl_s next_cur;

    // ************************************************************
    // update and read
    // ************************************************************
    // a locked-tight block only leaves that state through reset
    always_comb
    begin
        next_cur = cur;
        if (!aresetn)
        begin
            for (int i = 0; i < NBLK; i++)
            begin
                next_cur.st[i] = WP_RST;
            end
        end
        else if (lk.upd && cur.st[lk.blk] != LK_TIGHT)
        begin
            case (lk.kind)
                LKC_LOCK: next_cur.st[lk.blk] = LK_LOCKED;
                LKC_UNLOCK: next_cur.st[lk.blk] = LK_UNLOCKED;
                LKC_TIGHT: next_cur.st[lk.blk] = LK_TIGHT;
                default: next_cur.st[lk.blk] = cur.st[lk.blk];
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        cur <= next_cur;
    end

    assign lk.state = cur.st[lk.sel]; // status of the selected block

endmodule // fisr_lock_table

// *** core/fisr_regs.sv ***
// interrupt status, lock address and protection status registers
`timescale 1ns/1ps
module fisr_regs
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [fisr_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [fisr_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic op_done,
    input wire logic [15:0] op_code,
    input wire logic load_data_done,
    input wire logic boot_done,
    input wire logic warm_reset_busy,
    input wire logic lock_req,
    input wire fisr_pkg::fisr_lock_e lock_kind,
    output logic int_pin,
    output logic irq
);
    import fisr_pkg::*;

    typedef struct packed {
        fisr_ws_e ws;
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [15:0] widx;
        logic [15:0] wdata;
        logic [1:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [15:0] rdata;
        logic int_b;
        logic load_done_irq;
        logic program_done_irq;
        logic erase_done_irq;
        logic reset_done_irq;
        logic [BLK_W-1:0] lock_start_block;
        logic irq_polarity;
        logic [BLK_W-1:0] flash_block_select;
        logic [NEVT-1:0] evt;
        logic [NEVT-1:0] mask;
        logic busy_q;
        logic int_pin;
        logic irq;
    } fisr_top_s;
    fisr_top_s st;
    fisr_top_s next_st;
    fisr_lock_if lk ();
    logic aw_take, w_take, wr_fire, wr_isr, rst_rel;
    logic set_ld, set_pg, set_er, set_rs, set_cmd;
    logic [15:0] w_idx, w_dat, isr_val;
    logic [1:0] w_stb;
    logic [NEVT-1:0] evt_set;

    // ************************************************************
    // decode helpers
    // ************************************************************
    function automatic logic idx_ok(input logic [15:0] i);
        idx_ok = (i == IDX_ISR) || (i == IDX_LSB) || (i == IDX_LEB) ||
            (i == IDX_WPS) || (i == IDX_CTRL) || (i == IDX_FBS) ||
            (i == IDX_EVT) || (i == IDX_MASK);
    endfunction

    // status word as read; unnamed bits are constant zero
    assign isr_val = {st.int_b, 7'h00, st.load_done_irq,
        st.program_done_irq, st.erase_done_irq, st.reset_done_irq,
        4'h0};

    // ************************************************************
    // completion events
    // ************************************************************
    // release is seen on the first edge that samples busy low, against the copy in busy_q
    assign rst_rel = st.busy_q && !warm_reset_busy;
    assign set_ld = load_data_done || boot_done || (op_done &&
        (op_code == C_LD0 || op_code == C_LD1));
    assign set_pg = op_done && (op_code == C_PG0 ||
        op_code == C_PG1 || op_code == C_PG2);
    assign set_er = op_done && (op_code == C_ER0 ||
        op_code == C_ER1 || op_code == C_ER2);
    assign set_rs = rst_rel || (op_done && (op_code == C_RS0 ||
        op_code == C_RS1 || op_code == C_RS2));
    assign set_cmd = op_done && (op_code == C_MI0 ||
        op_code == C_MI1 || op_code == C_MI2 || op_code == C_MI3 ||
        op_code == C_MI4);
    assign evt_set = {set_cmd, set_rs, set_er, set_pg, set_ld};

    // ************************************************************
    // write channel capture
    // ************************************************************
    // address and data may arrive in either order; use the held copy
    assign aw_take = s_axi_awvalid && st.awready;
    assign w_take = s_axi_wvalid && st.wready;
    assign w_idx = st.aw_got ? st.widx : s_axi_awaddr[ADDR_W-1:2];
    assign w_dat = st.w_got ? st.wdata : s_axi_wdata[15:0];
    assign w_stb = st.w_got ? st.wstrb : s_axi_wstrb[1:0];
    assign wr_fire = (st.ws == WS_IDLE) && (st.aw_got || aw_take) &&
        (st.w_got || w_take);
    assign wr_isr = wr_fire && (w_idx == IDX_ISR);
    // protection table updates target the start block register; reads use the block select register
    assign lk.upd = lock_req;
    assign lk.blk = st.lock_start_block;
    assign lk.kind = lock_kind;
    assign lk.sel = st.flash_block_select;

    fisr_lock_table u_tbl (
        .aclk(aclk),
        .aresetn(aresetn),
        .lk(lk)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        next_st = st;
        // bus write side
        case (st.ws)
            WS_IDLE:
            begin
                if (aw_take)
                begin
                    next_st.aw_got = 1'b1;
                    next_st.widx = s_axi_awaddr[ADDR_W-1:2];
                end
                if (w_take)
                begin
                    next_st.w_got = 1'b1;
                    next_st.wdata = s_axi_wdata[15:0];
                    next_st.wstrb = s_axi_wstrb[1:0];
                end
                if (wr_fire)
                begin
                    next_st.ws = WS_RESP;
                    next_st.bvalid = 1'b1;
                    next_st.bresp = idx_ok(w_idx) ? RESP_OKAY :
                        RESP_SLVERR;
                    next_st.aw_got = 1'b0;
                    next_st.w_got = 1'b0;
                end
            end
            WS_RESP:
            begin
                if (s_axi_bready)
                begin
                    next_st.ws = WS_IDLE;
                    next_st.bvalid = 1'b0;
                end
            end
            default: next_st.ws = WS_IDLE;
        endcase
        next_st.awready = (next_st.ws == WS_IDLE) && !next_st.aw_got;
        next_st.wready = (next_st.ws == WS_IDLE) && !next_st.w_got;

        // plain register writes; the reserved location takes nothing
        if (wr_fire && w_idx == IDX_LSB)
        begin
            if (w_stb[0])
                next_st.lock_start_block[7:0] = w_dat[7:0];
            if (w_stb[1])
                next_st.lock_start_block[8] = w_dat[8];
        end
        if (wr_fire && w_idx == IDX_FBS)
        begin
            if (w_stb[0])
                next_st.flash_block_select[7:0] = w_dat[7:0];
            if (w_stb[1])
                next_st.flash_block_select[8] = w_dat[8];
        end
        if (wr_fire && w_idx == IDX_CTRL && w_stb[0])
            next_st.irq_polarity = w_dat[0];
        if (wr_fire && w_idx == IDX_MASK && w_stb[0])
            next_st.mask = w_dat[NEVT-1:0];

        // status flags: zero clears, one is ignored, a set wins
        if (wr_isr && w_stb[0])
        begin
            if (!w_dat[B_LOAD])
                next_st.load_done_irq = 1'b0;
            if (!w_dat[B_PROG])
                next_st.program_done_irq = 1'b0;
            if (!w_dat[B_ERASE])
                next_st.erase_done_irq = 1'b0;
            if (!w_dat[B_RST])
                next_st.reset_done_irq = 1'b0;
        end
        if (wr_isr && w_stb[1] && !w_dat[B_INT])
            next_st.int_b = 1'b0;
        if (set_ld)
            next_st.load_done_irq = 1'b1;
        if (set_pg)
            next_st.program_done_irq = 1'b1;
        if (set_er)
            next_st.erase_done_irq = 1'b1;
        if (set_rs)
            next_st.reset_done_irq = 1'b1;
        if (set_ld || set_pg || set_er || set_rs || set_cmd)
            next_st.int_b = 1'b1;
        // a reset in progress holds these low; the reset flag survives
        if (warm_reset_busy)
        begin
            next_st.int_b = 1'b0;
            next_st.load_done_irq = 1'b0;
            next_st.program_done_irq = 1'b0;
            next_st.erase_done_irq = 1'b0;
        end
        next_st.busy_q = warm_reset_busy;

        // sticky event copy, write one to clear, set beats clear
        if (wr_fire && w_idx == IDX_EVT && w_stb[0])
            next_st.evt = st.evt & ~w_dat[NEVT-1:0];
        next_st.evt = next_st.evt | evt_set;
        next_st.irq = |(next_st.evt & next_st.mask);
        // idle pin level is the inverse of the polarity setting
        next_st.int_pin = next_st.int_b ? next_st.irq_polarity :
            !next_st.irq_polarity;

        // bus read side
        if (st.rvalid && s_axi_rready)
            next_st.rvalid = 1'b0;
        if (s_axi_arvalid && st.arready)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp = RESP_OKAY;
            case (s_axi_araddr[ADDR_W-1:2])
                IDX_ISR: next_st.rdata = isr_val;
                IDX_LSB: next_st.rdata = {7'h00, st.lock_start_block};
                IDX_LEB: next_st.rdata = 16'h0000;
                IDX_WPS: next_st.rdata = {13'h0000, lk.state};
                IDX_CTRL: next_st.rdata = {15'h0000, st.irq_polarity};
                IDX_FBS: next_st.rdata = {7'h00, st.flash_block_select};
                IDX_EVT: next_st.rdata = {11'h000, st.evt};
                IDX_MASK: next_st.rdata = {11'h000, st.mask};
                default:
                begin
                    next_st.rdata = 16'h0000;
                    next_st.rresp = RESP_SLVERR;
                end
            endcase
        end
        next_st.arready = !next_st.rvalid;

        // cold reset values
        if (!aresetn)
        begin
            next_st = '0;
            next_st.ws = WS_IDLE;
            next_st.int_b = ISR_COLD[B_INT];
            next_st.load_done_irq = ISR_COLD[B_LOAD];
            next_st.program_done_irq = ISR_COLD[B_PROG];
            next_st.erase_done_irq = ISR_COLD[B_ERASE];
            next_st.reset_done_irq = ISR_COLD[B_RST];
            next_st.lock_start_block = BLK_RST;
            next_st.flash_block_select = BLK_RST;
            next_st.irq_polarity = POL_RST;
            next_st.mask = MASK_RST;
            next_st.int_pin = POL_RST;
        end
    end

    always_ff @(posedge aclk)
    begin
        st <= next_st;
    end

    // outputs come straight from the state flops
    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rdata = {16'h0000, st.rdata};
    assign int_pin = st.int_pin;
    assign irq = st.irq;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_warm_rel;
        st.busy_q && !warm_reset_busy && !op_done && !load_data_done &&
            !boot_done && !wr_isr;
    endsequence

    sequence s_rd(logic [15:0] i);
        s_axi_arvalid && st.arready && s_axi_araddr[ADDR_W-1:2] == i;
    endsequence

    a_pin_level: assert property (##1 int_pin == (st.int_b ?
        st.irq_polarity : !st.irq_polarity))
        else $error("interrupt pin disagrees with master bit");
    a_master_set: assert property ((set_cmd || set_pg) &&
        !warm_reset_busy |=> st.int_b)
        else $error("master bit not set on completion");
    a_busy_clear: assert property (warm_reset_busy |=> !st.int_b &&
        !st.load_done_irq && !st.program_done_irq)
        else $error("flags not cleared during reset");
    a_load_flag: assert property (set_ld && !warm_reset_busy |=>
        isr_val[B_LOAD] && st.int_b)
        else $error("load flag not set");
    a_prog_flag: assert property (set_pg && !warm_reset_busy |=>
        st.program_done_irq)
        else $error("program flag not set");
    a_erase_flag: assert property (set_er && !warm_reset_busy |=>
        st.erase_done_irq)
        else $error("erase flag not set");
    a_rst_flag: assert property ($fell(warm_reset_busy) |=>
        st.reset_done_irq)
        else $error("reset flag not set on release");
    a_rst_hold: assert property (st.reset_done_irq && !wr_isr |=>
        st.reset_done_irq)
        else $error("reset flag lost without a write");
    a_cold_value: assert property ($rose(aresetn) |-> isr_val ==
        ISR_COLD)
        else $error("wrong status after cold reset");
    a_warm_value: assert property (s_warm_rel |=> isr_val ==
        ISR_WARM)
        else $error("wrong status after warm reset");
    a_resv_read: assert property (s_rd(IDX_LEB) |=> s_axi_rvalid &&
        s_axi_rdata == 32'h0000_0000)
        else $error("reserved location read nonzero");
    a_wp_onehot: assert property (s_rd(IDX_WPS) |=> s_axi_rvalid &&
        $onehot(s_axi_rdata[2:0]) && s_axi_rdata[31:3] == 0)
        else $error("protection status not one-hot");
    a_one_keeps: assert property (wr_isr && w_stb[0] && w_dat[B_LOAD]
        && st.load_done_irq && !warm_reset_busy |=>
        st.load_done_irq)
        else $error("write of one changed load flag");

endmodule // fisr_regs

// *** sim/fisr_host.sv ***
// host model: an AXI4-Lite master that drives the register block
`timescale 1ns/1ps
module fisr_host
(
    input wire logic aclk,
    output logic [fisr_pkg::ADDR_W-1:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [fisr_pkg::ADDR_W-1:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    // bus idle at time zero
    initial
    begin
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end

    // one write; released payloads are inverted so stale data never matches
    task automatic wr(input logic [15:0] idx, input logic [15:0] d,
        output logic [1:0] r);
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
        awaddr <= ~awaddr;
        wdata <= ~wdata;
    endtask

    // one read, waits for rvalid however long the slave takes
    task automatic rd(input logic [15:0] idx, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        araddr <= ~araddr;
    endtask
endmodule // fisr_host

// *** sim/fisr_regs_tb.sv ***
// self-checking bench for the interrupt and lock registers
`timescale 1ns/1ps
module fisr_regs_tb;
    import fisr_pkg::*;
    logic aclk, aresetn, op_done, load_data_done, boot_done;
    logic warm_reset_busy, lock_req, int_pin, irq;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp, r;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [15:0] op_code, d, m_isr;
    fisr_lock_e lock_kind;
    int n_errors = 0, compares = 0, cycles = 0, seed = 32'h6fa6, i;
    logic [15:0] cmds [16] = '{C_LD0, C_LD1, C_PG0, C_PG1, C_PG2, C_ER0,
        C_ER1, C_ER2, C_RS0, C_RS1, C_RS2, C_MI0, C_MI1, C_MI2, C_MI3, C_MI4};
    int bitn [16] = '{7, 7, 6, 6, 6, 5, 5, 5, 4, 4, 4, 15, 15, 15, 15, 15};

    fisr_regs i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .op_done(op_done), .op_code(op_code),
        .load_data_done(load_data_done), .boot_done(boot_done),
        .warm_reset_busy(warm_reset_busy), .lock_req(lock_req),
        .lock_kind(lock_kind), .int_pin(int_pin), .irq(irq));
    fisr_host i_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));

    // 100 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // hang guard: the whole run needs a few hundred cycles
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_errors++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic w(input logic [15:0] idx, input logic [15:0] v);
        i_host.wr(idx, v, r);
    endtask

    // read a register and compare the whole 32-bit word
    task automatic rc(input logic [15:0] idx, input logic [31:0] e);
        logic [31:0] got;
        i_host.rd(idx, got, r);
        chk(got, e);
    endtask

    // one completion pulse: codes 0..15, then buffer load, then boot;
    // returns one edge after the pulse so its effect already shows
    task automatic fire(input int k);
        @(posedge aclk);
        if (k < 16)
        begin
            op_code <= cmds[k];
            op_done <= 1'b1;
        end
        else if (k == 16)
            load_data_done <= 1'b1;
        else
            boot_done <= 1'b1;
        @(posedge aclk);
        {op_done, load_data_done, boot_done} <= 3'b000;
        @(posedge aclk);
    endtask

    task automatic lk(input fisr_lock_e k);
        @(posedge aclk);
        lock_kind <= k;
        lock_req <= 1'b1;
        @(posedge aclk);
        lock_req <= 1'b0;
    endtask

    // main sequence: reset values, clears, events, warm reset, locking
    initial
    begin
        {aresetn, op_done, load_data_done, boot_done} = 4'h0;
        {warm_reset_busy, lock_req} = 2'b00;
        op_code = 16'h0000;
        lock_kind = LKC_LOCK;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk(int_pin, 1'b1);
        rc(IDX_ISR, ISR_COLD);
        rc(IDX_WPS, WP_RST);
        rc(IDX_LSB, 16'h0000);
        w(IDX_LEB, 16'hffff);
        chk(r, RESP_OKAY);
        rc(IDX_LEB, 16'h0000);
        chk(r, RESP_OKAY);
        rc(16'h0100, 16'h0000);
        chk(r, RESP_SLVERR);
        w(16'h0100, 16'h0000);
        chk(r, RESP_SLVERR);
        w(IDX_WPS, 16'h0004);
        rc(IDX_WPS, WP_RST);
        w(IDX_ISR, 16'hffff);
        rc(IDX_ISR, ISR_COLD);
        w(IDX_ISR, 16'h0000);
        rc(IDX_ISR, 16'h0000);
        chk(int_pin, 1'b0);
        w(IDX_CTRL, 16'h0000);
        chk(int_pin, 1'b1);
        w(IDX_CTRL, 16'h0001);
        w(IDX_MASK, 16'h001f);
        // every command code, buffer load and boot, flags and master predicted by the model
        for (i = 0; i < 18; i++)
        begin
            w(IDX_ISR, 16'h0000);
            w(IDX_EVT, 16'h001f);
            chk(irq, 1'b0);
            fire(i);
            m_isr = (i < 16) ? 16'h8000 | (16'h0001 << bitn[i]) : 16'h8080;
            rc(IDX_ISR, m_isr);
            chk(irq, 1'b1);
            chk(int_pin, 1'b1);
        end
        // masked event keeps irq low until unmasked
        w(IDX_EVT, 16'h001f);
        w(IDX_MASK, 16'h0000);
        fire(0);
        chk(irq, 1'b0);
        w(IDX_MASK, 16'h0001);
        chk(irq, 1'b1);
        w(IDX_EVT, 16'h001f);
        chk(irq, 1'b0);
        // warm reset clears all but the reset flag, release sets it
        w(IDX_ISR, 16'h0000);
        fire(8);
        fire(2);
        rc(IDX_ISR, 16'h8050);
        warm_reset_busy <= 1'b1;
        rc(IDX_ISR, 16'h0010);
        fire(0);
        rc(IDX_ISR, 16'h0010);
        warm_reset_busy <= 1'b0;
        repeat (3) @(posedge aclk);
        rc(IDX_ISR, ISR_WARM);
        // protection states of a random block; tight is final
        d = 16'($random(seed));
        w(IDX_LSB, d);
        rc(IDX_LSB, d & 16'h01ff);
        lk(LKC_UNLOCK);
        w(IDX_FBS, d);
        rc(IDX_WPS, LK_UNLOCKED);
        lk(LKC_LOCK);
        rc(IDX_WPS, LK_LOCKED);
        lk(LKC_TIGHT);
        rc(IDX_WPS, LK_TIGHT);
        lk(LKC_UNLOCK);
        rc(IDX_WPS, LK_TIGHT);
        w(IDX_FBS, {7'h00, ~d[8:0]});
        rc(IDX_WPS, LK_LOCKED);
        complete_run();
    end
endmodule // fisr_regs_tb
